// file: src/mmd_diag_top.sv
// Diagnostics controller with two-wire serial memory and power-down reset
//
// Overview of operation
// - Power-down input high holds standby
// - Power-down falling edge resets everything
// - Capture on rising clock; protected bytes unchanged
// - Drive read bits from falling clock
// - Detect start and stop on data
// - Byte memory from zero, random and sequential
// - Five live measurements readable
// - Flags set when outside threshold range
// - Controller runs on the reference clock; only the link runs on the serial clock
// - Respond only while deselect is low
// - Active low interrupt on any flag
`timescale 1ns/1ps
`include "mmd_regs.svh"
module mmd_diag_top
    import mmd_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `MMD_DEV_ADDR,
    parameter int MEM_DEPTH = 224
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic pdown_reset,
    input wire logic deselect,
    input wire logic thr_unlock,
    input mmd_meas_s meas,
    output logic standby,
    output logic int_n_o,
    output logic int_n_oe,
    output mmd_flags_s flags
);
    // Whole state of the controller
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] tgl_s;
        logic [1:0] bit_s;
        logic [2:0] pd_s;
        logic [1:0] desel_s;
        logic [1:0] unlk_s;
        mmd_st_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] rd;
        logic [7:0] ptr;
        logic tx;
        logic link_rst;
        mmd_flags_s flg;
        logic [MEM_DEPTH-1:0][7:0] mem;
    } mmd_state_s;

    // Reset image, thresholds open so no flag fires
    function automatic mmd_state_s mmd_rst_state();
        mmd_state_s s;
        s = '0;
        s.st = ST_IDLE;
        s.tx = 1'b1;
        s.link_rst = 1'b1;
        for (int i = 0; i < MMD_NMEAS * 4; i++) begin
            s.mem[i] = (i[0] == 1'b0) ? `MMD_THR_HI_RST : `MMD_THR_LO_RST;
        end
        return s;
    endfunction

    localparam mmd_state_s RST_VAL = mmd_rst_state();

    mmd_state_s r;
    mmd_state_s n;
    // Link domain outputs
    mmd_rx_s link_rx;
    // Measurements as an indexed array, temp first
    logic [MMD_NMEAS-1:0][15:0] meas_a;
    // Flags computed from current measurements
    logic [MMD_NMEAS-1:0] alarm_c;
    logic [MMD_NMEAS-1:0] warn_c;
    // Decoded bus events
    logic start_ev;
    logic stop_ev;
    logic rx_ev;
    logic rx_bit;
    logic pd_fall;
    logic busy_ok;
    logic [7:0] byte_in;
    logic [7:0] rd_next;
    // Byte at the current pointer, first read byte
    logic [7:0] rd_cur;
    logic [7:0] ptr_inc;

    // Index order matches flag bit order
    assign meas_a[0] = meas.temp;
    assign meas_a[1] = meas.bias;
    assign meas_a[2] = meas.tx_power;
    assign meas_a[3] = meas.rx_power;
    assign meas_a[4] = meas.supply;

    // Per measurement compare of high byte against thresholds
    for (genvar g = 0; g < MMD_NMEAS; g++) begin : g_cmp
        localparam int B = g * 4;
        assign alarm_c[g] =
            (meas_a[g][15:8] > r.mem[B + `MMD_THR_AHI]) ||
            (meas_a[g][15:8] < r.mem[B + `MMD_THR_ALO]);
        assign warn_c[g] =
            (meas_a[g][15:8] > r.mem[B + `MMD_THR_WHI]) ||
            (meas_a[g][15:8] < r.mem[B + `MMD_THR_WLO]);
    end

    // Read path over the whole byte map
    function automatic logic [7:0] rd_byte(input mmd_state_s s,
                                           input logic [7:0] a);
        logic [7:0] v;
        logic [7:0] idx;
        v = `MMD_RD_NONE;
        idx = 8'h00;
        if (a < `MMD_OFS_MEAS_END) begin
            idx = (a - `MMD_OFS_MEAS) >> 1;
            v = a[0] ? meas_a[idx[2:0]][7:0] : meas_a[idx[2:0]][15:8];
        end else if (a == `MMD_OFS_ALARM) begin
            v = {3'h0, s.flg.alarm};
        end else if (a == `MMD_OFS_WARN) begin
            v = {3'h0, s.flg.warn};
        end else if (a >= `MMD_OFS_THR) begin
            v = s.mem[a - `MMD_OFS_THR];
        end
        return v;
    endfunction

    // Events from synchronised pins, newest stage 1, older stage 2
    always_comb begin
        start_ev = r.scl_s[1] && r.scl_s[2] &&
                   r.sda_s[2] && !r.sda_s[1];
        stop_ev = r.scl_s[1] && r.scl_s[2] &&
                  !r.sda_s[2] && r.sda_s[1];
        rx_ev = r.tgl_s[1] != r.tgl_s[2];
        rx_bit = r.bit_s[1];
        pd_fall = r.pd_s[2] && !r.pd_s[1];
        busy_ok = !r.desel_s[1] && !r.pd_s[1];
        byte_in = {r.sh[6:0], rx_bit};
        ptr_inc = r.ptr + 8'h01;
        rd_next = rd_byte(r, ptr_inc);
        rd_cur = rd_byte(r, r.ptr);
    end

    // Next state of the controller
    always_comb begin
        n = r;
        // Pin and crossing synchronisers
        n.scl_s = {r.scl_s[1:0], scl};
        n.sda_s = {r.sda_s[1:0], sda_i};
        n.tgl_s = {r.tgl_s[1:0], link_rx.tgl};
        n.bit_s = {r.bit_s[0], link_rx.bit_v};
        n.pd_s = {r.pd_s[1:0], pdown_reset};
        n.desel_s = {r.desel_s[0], deselect};
        n.unlk_s = {r.unlk_s[0], thr_unlock};
        // Flags follow the live compare every cycle
        n.flg.alarm = alarm_c;
        n.flg.warn = warn_c;
        // Standby holds the link logic in reset
        n.link_rst = r.pd_s[1];
        if (!busy_ok) begin
            // Deselected or standby: bus traffic ignored
            n.st = ST_IDLE;
            n.tx = 1'b1;
        end else if (start_ev) begin
            // Start or repeated start
            n.st = ST_DEV;
            n.cnt = 4'h0;
            n.tx = 1'b1;
        end else if (stop_ev) begin
            // Stop ends the transaction
            n.st = ST_IDLE;
            n.tx = 1'b1;
        end else if (rx_ev && r.st != ST_IDLE) begin
            n.cnt = r.cnt + 4'h1;
            if (r.st == ST_RD) begin
                if (r.cnt < `MMD_BIT_LAST) begin
                    // Next read bit, out on the coming fall
                    n.tx = r.rd[3'h6 - r.cnt[2:0]];
                end else if (r.cnt == `MMD_BIT_LAST) begin
                    // Release for the host acknowledge
                    n.tx = 1'b1;
                end else begin
                    n.cnt = 4'h0;
                    if (!rx_bit) begin
                        // Host acknowledged: next location
                        n.ptr = ptr_inc;
                        n.rd = rd_next;
                        n.tx = rd_next[7];
                    end else begin
                        // Host declined: done
                        n.st = ST_IDLE;
                        n.tx = 1'b1;
                    end
                end
            end else if (r.cnt < `MMD_BIT_ACK) begin
                // Receive a byte, most significant bit first
                n.sh = byte_in;
                if (r.cnt == `MMD_BIT_LAST) begin
                    n.tx = 1'b0;
                    case (r.st)
                        ST_DEV: begin
                            // Acknowledge own address only
                            if (byte_in[7:1] != DEV_ADDR) begin
                                n.st = ST_IDLE;
                                n.tx = 1'b1;
                            end
                        end
                        ST_ADR: begin
                            // Random access start address
                            n.ptr = byte_in;
                        end
                        ST_WR: begin
                            // Protected bytes keep their contents
                            if (r.ptr >= `MMD_OFS_USER ||
                                (r.ptr >= `MMD_OFS_THR && r.unlk_s[1])) begin
                                n.mem[r.ptr - `MMD_OFS_THR] = byte_in;
                            end
                            n.ptr = ptr_inc;
                        end
                        default: begin
                            n.st = ST_IDLE;
                        end
                    endcase
                end
            end else begin
                // Acknowledge clock done, pick next phase
                n.cnt = 4'h0;
                n.tx = 1'b1;
                case (r.st)
                    ST_DEV: begin
                        if (r.sh[0]) begin
                            // Read from current address
                            n.st = ST_RD;
                            n.rd = rd_cur;
                            n.tx = rd_cur[7];
                        end else begin
                            n.st = ST_ADR;
                        end
                    end
                    ST_ADR: begin
                        n.st = ST_WR;
                    end
                    ST_WR: begin
                        n.st = ST_WR;
                    end
                    default: begin
                        n.st = ST_IDLE;
                    end
                endcase
            end
        end
        // Falling power-down edge: full reset as at power up
        if (pd_fall) begin
            n = RST_VAL;
            n.pd_s = {r.pd_s[1:0], pdown_reset};
        end
    end

    // Register the whole state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= RST_VAL;
        end else begin
            r <= n;
        end
    end

    // Serial clock domain, its own clock and no reference clock used
    mmd_link_edge u_link (
        .scl_clk(scl),
        .link_reset(r.link_rst),
        .sda_i(sda_i),
        .tx_level(r.tx),
        .rx(link_rx),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    // Outputs from registered state
    assign standby = r.pd_s[1];
    assign int_n_o = 1'b0;
    assign int_n_oe = |{r.flg.alarm, r.flg.warn};
    assign flags = r.flg;
endmodule

// file: src/mmd_regs.svh
// Memory offsets, reset values and timing counts of the management block
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
// Live measurements, two bytes each, high byte first
`define MMD_OFS_MEAS 8'h00
// Measurement region end, first address past the last live byte
`define MMD_OFS_MEAS_END 8'h0a
// Alarm flag byte, one bit per measurement
`define MMD_OFS_ALARM 8'h0a
// Warning flag byte, one bit per measurement
`define MMD_OFS_WARN 8'h0b
// Threshold segment: four bytes per measurement
`define MMD_OFS_THR 8'h20
// Byte positions inside one threshold group
`define MMD_THR_AHI 2'h0
`define MMD_THR_ALO 2'h1
`define MMD_THR_WHI 2'h2
`define MMD_THR_WLO 2'h3
// User segment, always writable
`define MMD_OFS_USER 8'h40
// Reset values of high and low thresholds
`define MMD_THR_HI_RST 8'hff
`define MMD_THR_LO_RST 8'h00
// Value read from unmapped bytes
`define MMD_RD_NONE 8'h00
// Bus address of the module, arbitrary value
`define MMD_DEV_ADDR 7'h50
// Bit counts within one byte slot
`define MMD_BIT_LAST 4'h7
`define MMD_BIT_ACK 4'h8
`endif

// file: src/mmd_pkg.sv
// Types shared by the management serial block
package mmd_pkg;
    // Number of live measurements
    localparam int MMD_NMEAS = 5;
    // Protocol states of the serial slave
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ADR,
        ST_WR,
        ST_RD
    } mmd_st_e;
    // Live measurements from the monitoring front end
    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] bias;
        logic [15:0] tx_power;
        logic [15:0] rx_power;
        logic [15:0] supply;
    } mmd_meas_s;
    // Alarm and warning flags, bit 0 is temp, bit 4 is supply
    typedef struct packed {
        logic [4:0] alarm;
        logic [4:0] warn;
    } mmd_flags_s;
    // Signals crossing from the link domain
    typedef struct packed {
        logic tgl;
        logic bit_v;
    } mmd_rx_s;
endpackage

// file: src/mmd_link_edge.sv
// Serial clock domain: bit capture and data drive of the two-wire link
`timescale 1ns/1ps
module mmd_link_edge
    import mmd_pkg::*;
(
    input wire logic scl_clk,
    input wire logic link_reset,
    input wire logic sda_i,
    input wire logic tx_level,
    output mmd_rx_s rx,
    output logic sda_o,
    output logic sda_oe
);
    // Capture state: toggle per rising edge plus sampled bit
    mmd_rx_s rx_r;
    mmd_rx_s rx_nxt;
    // Drive state: high while pulling the data line low
    logic drv_r;
    logic drv_nxt;

    // Next capture and drive values
    always_comb begin
        rx_nxt.tgl = ~rx_r.tgl;
        rx_nxt.bit_v = sda_i;
        drv_nxt = ~tx_level;
    end

    // Sample data on rising serial clock
    always_ff @(posedge scl_clk or posedge link_reset) begin
        if (link_reset) begin
            rx_r <= '0;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    // Change driven bit on falling serial clock
    always_ff @(negedge scl_clk or posedge link_reset) begin
        if (link_reset) begin
            drv_r <= 1'b0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    // Open drain: only ever pull low, never touch the clock line
    assign rx = rx_r;
    assign sda_o = 1'b0;
    assign sda_oe = drv_r;
endmodule

// file: tb/mmd_diag_chk.sv
// Port checks of the management block
`timescale 1ns/1ps
module mmd_diag_chk
    import mmd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic pdown_reset,
    input wire logic deselect,
    input wire logic thr_unlock,
    input mmd_meas_s meas,
    input wire logic standby,
    input wire logic int_n_o,
    input wire logic int_n_oe,
    input mmd_flags_s flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_PD_STANDBY: assert property (pdown_reset [*4] |-> standby)
        else $error("no standby");
    AST_PD_AWAKE: assert property (!pdown_reset [*4] |-> !standby)
        else $error("stuck standby");
    AST_PD_QUIET: assert property (standby |-> !sda_oe)
        else $error("drive in standby");
    AST_PD_CLEAR: assert property ($fell(pdown_reset) |-> ##[2:8]
        (flags == 10'h000)) else $error("flags kept");
    // Read bits only move while the clock is low
    AST_DATA_EDGE: assert property ($changed(sda_oe) |-> !scl)
        else $error("data moved high");
    AST_DESEL_QUIET: assert property (deselect [*4] |-> !sda_oe)
        else $error("answered deselected");
    AST_INT_SET: assert property ((flags != 10'h000) [*3] |-> int_n_oe)
        else $error("no interrupt");
    AST_INT_CLR: assert property ((flags == 10'h000) [*3] |-> !int_n_oe)
        else $error("stray interrupt");
    AST_OPEN_DRAIN: assert property (!sda_o && !int_n_o)
        else $error("pin driven high");
    cover property ($rose(standby));
    cover property ($rose(int_n_oe));
    cover property ($rose(sda_oe));
endmodule
bind mmd_diag_top mmd_diag_chk chk_u (.clk(clk), .reset(reset), .scl(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .meas(meas),
    .pdown_reset(pdown_reset), .deselect(deselect), .flags(flags),
    .thr_unlock(thr_unlock), .standby(standby), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe));

// file: tb/mmd_host.sv
// Host of the two-wire link: sole clock source, data pulled low only
`timescale 1ns/1ps
module mmd_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Idle: clock high and still, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Data bit, changed in the low phase
    task automatic bt(input logic b);
        sda_low = ~b;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
        #40;
    endtask
    // Bit from the module, taken mid high phase
    task automatic br(output logic b);
        sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 b = sda;
        #40 scl = 1'b0;
        #40;
    endtask
    // Start or repeated start
    task automatic st();
        #3 sda_low = 1'b0;
        #40 scl = 1'b1;
        #100 sda_low = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask
    // Stop, then the clock stands still
    task automatic sp();
        sda_low = 1'b1;
        #40 scl = 1'b1;
        #100 sda_low = 1'b0;
        #200;
    endtask
    // Byte out, acknowledge back
    task automatic wb(input logic [7:0] v, output logic ak);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bt(v[i]);
        end
        br(b);
        ak = ~b;
    endtask
    // Byte in, then acknowledge or not
    task automatic rb(output logic [7:0] v, input logic nak);
        for (int i = 7; i >= 0; i--) begin
            br(v[i]);
        end
        bt(nak);
    endtask
endmodule

// file: tb/mmd_diag_tb_top.sv
// Self-checking bench of the management block
`timescale 1ns/1ps
module mmd_diag_tb_top
    import mmd_pkg::*;
;
    logic clk, reset, scl, sda_low, sda, sda_o, sda_oe, standby;
    logic pdown_reset, deselect, thr_unlock, int_n_o, int_n_oe;
    mmd_meas_s meas;
    mmd_flags_s flags;
    int n_mismatch = 0;
    int total_checks = 0;
    // Pulled-up wire
    assign sda = ~(sda_low | (sda_oe & ~sda_o));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    mmd_diag_top dut_u (.clk(clk), .reset(reset), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .pdown_reset(pdown_reset),
        .deselect(deselect), .thr_unlock(thr_unlock), .meas(meas),
        .standby(standby), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .flags(flags));
    mmd_host host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    // Single bit results: acknowledge, standby, interrupt
    task automatic chk_bit(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t bit got %b want %b", $time, g, e);
        end
    endtask
    // Byte results read over the link
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t byte got %h want %h", $time, g, e);
        end
    endtask
    // Two bytes written from address a
    task automatic wr2(input logic [7:0] a, d0, d1);
        logic ak;
        host_u.st();
        host_u.wb(8'ha0, ak);
        host_u.wb(a, ak);
        host_u.wb(d0, ak);
        host_u.wb(d1, ak);
        host_u.sp();
        chk_bit(ak, 1'b1);
    endtask
    // Random read of two bytes from address a
    task automatic rd2(input logic [7:0] a, e0, e1);
        logic ak;
        logic [7:0] q0, q1;
        host_u.st();
        host_u.wb(8'ha0, ak);
        host_u.wb(a, ak);
        host_u.st();
        host_u.wb(8'ha1, ak);
        host_u.rb(q0, 1'b0);
        host_u.rb(q1, 1'b1);
        host_u.sp();
        chk_byte(q0, e0);
        chk_byte(q1, e1);
    endtask
    // Address byte that must go unanswered
    task automatic nack(input logic [7:0] v);
        logic ak;
        host_u.st();
        host_u.wb(v, ak);
        host_u.sp();
        chk_bit(ak, 1'b0);
    endtask
    // Current-address read of one byte
    task automatic cur1(input logic [7:0] e);
        logic ak;
        logic [7:0] q;
        host_u.st();
        host_u.wb(8'ha1, ak);
        host_u.rb(q, 1'b1);
        host_u.sp();
        chk_bit(ak, 1'b1);
        chk_byte(q, e);
    endtask
    task automatic t_meas();
        logic [79:0] m;
        m = meas;
        for (int i = 0; i < 10; i += 2) begin
            rd2(8'(i), m[79-8*i -: 8], m[71-8*i -: 8]);
        end
        rd2(8'h0a, 8'h00, 8'h00);
        rd2(8'h1f, 8'h00, 8'hff);
        $display("test meas done");
    endtask
    task automatic t_wr();
        wr2(8'h40, 8'h5a, 8'ha5);
        rd2(8'h40, 8'h5a, 8'ha5);
        wr2(8'h00, 8'h12, 8'h34);
        rd2(8'h00, 8'h30, 8'h12);
        wr2(8'hff, 8'h77, 8'h66);
        cur1(8'h12);
        rd2(8'hff, 8'h77, 8'h30);
        $display("test write done");
    endtask
    task automatic t_thr();
        wr2(8'h20, 8'h10, 8'h00);
        rd2(8'h20, 8'hff, 8'h00);
        @(negedge clk) thr_unlock = 1'b1;
        wr2(8'h20, 8'h10, 8'h00);
        wr2(8'h22, 8'hff, 8'h40);
        rd2(8'h0a, 8'h01, 8'h01);
        wr2(8'h26, 8'h40, 8'h00);
        wr2(8'h31, 8'h80, 8'hff);
        rd2(8'h0a, 8'h11, 8'h03);
        @(negedge clk) thr_unlock = 1'b0;
        chk(flags, 10'h223);
        chk_bit(int_n_oe, 1'b1);
        $display("test threshold done");
    endtask
    task automatic t_sel();
        @(negedge clk) deselect = 1'b1;
        repeat (4) @(negedge clk);
        nack(8'ha0);
        @(negedge clk) deselect = 1'b0;
        nack(8'ha2);
        $display("test deselect done");
    endtask
    task automatic t_pd();
        @(negedge clk) pdown_reset = 1'b1;
        repeat (4) @(negedge clk);
        chk_bit(standby, 1'b1);
        nack(8'ha0);
        @(negedge clk) pdown_reset = 1'b0;
        repeat (8) @(negedge clk);
        chk_bit(standby, 1'b0);
        chk(flags, 10'h000);
        chk_bit(int_n_oe, 1'b0);
        rd2(8'h20, 8'hff, 8'h00);
        $display("test power down done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        pdown_reset = 1'b0;
        deselect = 1'b0;
        thr_unlock = 1'b0;
        meas = {16'h3012, 16'h4534, 16'h5656, 16'h6778, 16'h7a9b};
        repeat (16) @(negedge clk);
        reset = 1'b0;
        repeat (130) @(negedge clk);
        t_meas();
        t_wr();
        t_thr();
        t_sel();
        t_pd();
        complete_run();
    end
    // Hang guard, well past the expected run
    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end
endmodule
